// file: shared/t3c_defines.svh
// register map, field positions, reset values and timing counts
`ifndef T3C_DEFINES_SVH
`define T3C_DEFINES_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define T3C_CLK_MHZ       250
`define T3C_INSTR_DIV     4
`define T3C_PHASES        2
`define T3C_PHASE_DIV     (`T3C_INSTR_DIV / `T3C_PHASES)
// ------------------------------------------------------------
// register banks and offsets
// ------------------------------------------------------------
`define T3C_BANK_FLAGS1   3'h1
`define T3C_OFF_FLAGS1    5'h16
`define T3C_BANK_MASKS1   3'h1
`define T3C_OFF_MASKS1    5'h17
`define T3C_BANK_FLAGS2   3'h4
`define T3C_OFF_FLAGS2    5'h10
`define T3C_BANK_MASKS2   3'h4
`define T3C_OFF_MASKS2    5'h11
`define T3C_BANK_CNT      3'h2
`define T3C_OFF_CNT_LO    5'h12
`define T3C_OFF_CNT_HI    5'h13
`define T3C_BANK_FIRST_CAPTURE_PIN     3'h2
`define T3C_OFF_FIRST_CAPTURE_PIN_LO   5'h16
`define T3C_OFF_FIRST_CAPTURE_PIN_HI   5'h17
`define T3C_BANK_CAP2     3'h3
`define T3C_OFF_CAP2_LO   5'h14
`define T3C_OFF_CAP2_HI   5'h15
`define T3C_BANK_CAP34    3'h7
`define T3C_OFF_CAP3_LO   5'h12
`define T3C_OFF_CAP3_HI   5'h13
`define T3C_OFF_CAP4_LO   5'h14
`define T3C_OFF_CAP4_HI   5'h15
`define T3C_BANK_TCTL12   3'h3
`define T3C_OFF_TCTL1     5'h16
`define T3C_OFF_TCTL2     5'h17
`define T3C_BANK_TCTL3    3'h7
`define T3C_OFF_TCTL3     5'h16
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define T3C_B_WRAP        6
`define T3C_B_CAP1F       2
`define T3C_B_CAP2F       3
`define T3C_B_CAP3F       2
`define T3C_B_CAP4F       3
`define T3C_B_ED2         6
`define T3C_B_ED1         4
`define T3C_B_SRC         2
`define T3C_B_OVF2        7
`define T3C_B_OVF1        6
`define T3C_B_FCS         3
`define T3C_B_RUN         2
`define T3C_B_OVF4        6
`define T3C_B_OVF3        5
`define T3C_B_ED4         3
`define T3C_B_ED3         1
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define T3C_RST_BYTE      8'h00
`define T3C_RST_WORD      16'h0000
`define T3C_CNT_TOP       16'hFFFF
`endif

// file: shared/t3c_pkg.sv
// types shared by the timer/capture block
package t3c_pkg;
  typedef enum logic [1:0] {
    T3C_EDGE_FALL,
    T3C_EDGE_RISE,
    T3C_EDGE_RISE4,
    T3C_EDGE_RISE16
  } t3c_edge_t;

  typedef struct packed {
    logic full;
    logic rd_lo;
    logic rd_hi;
    logic master;
    logic ovf;
    logic flag;
  } t3c_chan_t;
endpackage

// file: rtl/t3c_top.sv
// 16-bit timebase with four capture channels, Avalon-MM slave
// How it works
// - mode bit turns period pair into capture
// - four-capture mode counts full 16-bit range
// - wrap sets flag; software clears it
// - period pair match clears counter and sets wrap flag
// - edge field picks event; flag, mask
// - channels two to four always capture; channel one captures only with the mode bit set
// - event on unread word sets master overflow
// - unread word is never overwritten
// - both bytes read moves master to status
// - source bit counts external falling edges
// - external input sampled twice per cycle
// - run bit gates counting and wrap flag
// - internal source counts each instruction cycle
// - edge choices: fall, rise, 4th, 16th
// - prescaler cleared only by reset
`timescale 1ns/1ns
`include "t3c_defines.svh"
module t3c_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // pins
  input  wire logic [3:0]  capture_event_pin,
  input  wire logic        external_count_clock,
  // request to the interrupt controller
  output logic             capture_timer_req
);
  localparam logic [7:0] A_FLG1 = {`T3C_BANK_FLAGS1, `T3C_OFF_FLAGS1};
  localparam logic [7:0] A_MSK1 = {`T3C_BANK_MASKS1, `T3C_OFF_MASKS1};
  localparam logic [7:0] A_FLG2 = {`T3C_BANK_FLAGS2, `T3C_OFF_FLAGS2};
  localparam logic [7:0] A_MSK2 = {`T3C_BANK_MASKS2, `T3C_OFF_MASKS2};
  localparam logic [7:0] A_CNTL = {`T3C_BANK_CNT, `T3C_OFF_CNT_LO};
  localparam logic [7:0] A_CNTH = {`T3C_BANK_CNT, `T3C_OFF_CNT_HI};
  localparam logic [7:0] A_TC1  = {`T3C_BANK_TCTL12, `T3C_OFF_TCTL1};
  localparam logic [7:0] A_TC2  = {`T3C_BANK_TCTL12, `T3C_OFF_TCTL2};
  localparam logic [7:0] A_TC3  = {`T3C_BANK_TCTL3, `T3C_OFF_TCTL3};
  localparam logic [1:0] DIV_LAST = 2'(`T3C_INSTR_DIV - 1);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [7:0] cap_adr(input int ch, input logic hi);
    logic [4:0] off;
    off = 5'h00;
    unique case (ch)
      0: off = hi ? `T3C_OFF_FIRST_CAPTURE_PIN_HI : `T3C_OFF_FIRST_CAPTURE_PIN_LO;
      1: off = hi ? `T3C_OFF_CAP2_HI : `T3C_OFF_CAP2_LO;
      2: off = hi ? `T3C_OFF_CAP3_HI : `T3C_OFF_CAP3_LO;
      default: off = hi ? `T3C_OFF_CAP4_HI : `T3C_OFF_CAP4_LO;
    endcase
    if (ch == 0)
      cap_adr = {`T3C_BANK_FIRST_CAPTURE_PIN, off};
    else if (ch == 1)
      cap_adr = {`T3C_BANK_CAP2, off};
    else
      cap_adr = {`T3C_BANK_CAP34, off};
  endfunction

  function automatic logic edge_event(input logic [1:0] sel,
                                      input logic rise,
                                      input logic fall,
                                      input logic [3:0] presc);
    t3c_pkg::t3c_edge_t mode;
    mode = t3c_pkg::t3c_edge_t'(sel);
    unique case (mode)
      t3c_pkg::T3C_EDGE_FALL:   edge_event = fall;
      t3c_pkg::T3C_EDGE_RISE:   edge_event = rise;
      t3c_pkg::T3C_EDGE_RISE4:  edge_event = rise & (presc[1:0] == 2'h3);
      t3c_pkg::T3C_EDGE_RISE16: edge_event = rise & (presc == 4'hF);
    endcase
  endfunction

  // ----------------------------------------------------------
  // bus slave: one wait state, then accept
  // ----------------------------------------------------------
  logic       ack_r;
  logic       rd_acc;
  logic       wr_acc;
  logic [7:0] wd;
  logic [7:0] rd_val;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign rd_acc = avs_read & ack_r;
  assign wr_acc = avs_write & ack_r & avs_byteenable[0];
  assign wd     = avs_writedata[7:0];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_r)
      avs_readdata <= {24'h00_0000, rd_val};
  end

  // ----------------------------------------------------------
  // instruction cycle and phase enables
  // ----------------------------------------------------------
  logic [1:0] div_r;
  logic       instr_en;
  logic       phase_en;

  assign instr_en = (div_r == DIV_LAST);
  assign phase_en = div_r[0];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 2'h0;
    else
      div_r <= 2'(div_r + 2'h1);
  end

  // ----------------------------------------------------------
  // pin sampling on the phase enables
  // ----------------------------------------------------------
  logic [2:0] ext_s_r;
  logic [3:0] cap_s1_r;
  logic [3:0] cap_s2_r;
  logic [3:0] cap_s3_r;
  logic       ext_fall;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s_r  <= 3'h7;
      cap_s1_r <= 4'h0;
      cap_s2_r <= 4'h0;
      cap_s3_r <= 4'h0;
    end
    else if (phase_en)
    begin
      ext_s_r  <= {ext_s_r[1:0], external_count_clock};
      cap_s1_r <= capture_event_pin;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  // edges are judged on stages two and three only
  assign ext_fall = phase_en & ext_s_r[2] & ~ext_s_r[1];
  assign pin_rise = {4{phase_en}} & cap_s2_r & ~cap_s3_r;
  assign pin_fall = {4{phase_en}} & ~cap_s2_r & cap_s3_r;

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  logic       src_r;
  logic       run_r;
  logic       fcs_r;
  logic [1:0] ed_r [4];
  logic [4:0] msk_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_r <= 1'b0;
      run_r <= 1'b0;
      fcs_r <= 1'b0;
      msk_r <= 5'h00;
      for (int i = 0; i < 4; i++)
        ed_r[i] <= 2'h0;
    end
    else if (wr_acc)
    begin
      if (avs_address == A_TC1)
      begin
        ed_r[0] <= wd[`T3C_B_ED1 +: 2];
        ed_r[1] <= wd[`T3C_B_ED2 +: 2];
        src_r   <= wd[`T3C_B_SRC];
      end
      if (avs_address == A_TC2)
      begin
        fcs_r <= wd[`T3C_B_FCS];
        run_r <= wd[`T3C_B_RUN];
      end
      if (avs_address == A_TC3)
      begin
        ed_r[2] <= wd[`T3C_B_ED3 +: 2];
        ed_r[3] <= wd[`T3C_B_ED4 +: 2];
      end
      if (avs_address == A_MSK1)
      begin
        msk_r[0] <= wd[`T3C_B_CAP1F];
        msk_r[1] <= wd[`T3C_B_CAP2F];
        msk_r[4] <= wd[`T3C_B_WRAP];
      end
      if (avs_address == A_MSK2)
      begin
        msk_r[2] <= wd[`T3C_B_CAP3F];
        msk_r[3] <= wd[`T3C_B_CAP4F];
      end
    end
  end

  // ----------------------------------------------------------
  // timebase counter
  // ----------------------------------------------------------
  logic [15:0] cnt_r;
  logic [15:0] cap_r [4];
  logic        tick;
  logic        at_period;
  logic        wrap_set;
  logic        wrap_r;

  assign tick      = run_r & (src_r ? ext_fall : instr_en);
  assign at_period = ~fcs_r & (cnt_r == cap_r[0]);
  assign wrap_set  = tick & (fcs_r ? (cnt_r == `T3C_CNT_TOP)
                                   : at_period);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= `T3C_RST_WORD;
    else if (wr_acc && avs_address == A_CNTL)
      cnt_r[7:0] <= wd;
    else if (wr_acc && avs_address == A_CNTH)
      cnt_r[15:8] <= wd;
    else if (tick)
      cnt_r <= at_period ? `T3C_RST_WORD : 16'(cnt_r + 16'h0001);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wrap_r <= 1'b0;
    else if (wrap_set)
      wrap_r <= 1'b1;
    else if (wr_acc && avs_address == A_FLG1)
      wrap_r <= wd[`T3C_B_WRAP];
  end

  // ----------------------------------------------------------
  // capture channels
  // ----------------------------------------------------------
  t3c_pkg::t3c_chan_t ch_r [4];
  logic [3:0]         presc_r [4];
  logic [3:0]         ev;
  logic [3:0]         hit_lo;
  logic [3:0]         hit_hi;
  logic [3:0]         done;
  logic [3:0]         flg_wr;
  logic [3:0]         flg_wd;

  assign flg_wr = {{2{wr_acc && avs_address == A_FLG2}},
                   {2{wr_acc && avs_address == A_FLG1}}};
  assign flg_wd = {wd[`T3C_B_CAP4F], wd[`T3C_B_CAP3F],
                   wd[`T3C_B_CAP2F], wd[`T3C_B_CAP1F]};

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      ev[i] = edge_event(ed_r[i], pin_rise[i], pin_fall[i],
                         presc_r[i]);
      if (i == 0)
        ev[i] = ev[i] & fcs_r;
      hit_lo[i] = rd_acc && avs_address == cap_adr(i, 1'b0);
      hit_hi[i] = rd_acc && avs_address == cap_adr(i, 1'b1);
      done[i]   = ch_r[i].full & (ch_r[i].rd_lo | hit_lo[i])
                               & (ch_r[i].rd_hi | hit_hi[i]);
    end
  end

  // prescaler counts every rising edge whatever the mode
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < 4; i++)
        presc_r[i] <= 4'h0;
    else
      for (int i = 0; i < 4; i++)
        if (pin_rise[i])
          presc_r[i] <= 4'(presc_r[i] + 4'h1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < 4; i++)
        cap_r[i] <= `T3C_RST_WORD;
    else
    begin
      for (int i = 0; i < 4; i++)
        if (ev[i] && !ch_r[i].full)
          cap_r[i] <= cnt_r;
      // period duty only: captured words stay software-proof
      if (wr_acc && !fcs_r && avs_address == cap_adr(0, 1'b0))
        cap_r[0][7:0] <= wd;
      if (wr_acc && !fcs_r && avs_address == cap_adr(0, 1'b1))
        cap_r[0][15:8] <= wd;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < 4; i++)
        ch_r[i] <= '0;
    else
      for (int i = 0; i < 4; i++)
      begin
        // an event on the releasing read marks the old word full again, uncaptured
        ch_r[i].full   <= ev[i] | (ch_r[i].full & ~done[i]);
        ch_r[i].rd_lo  <= ~done[i] & ch_r[i].full
                          & (ch_r[i].rd_lo | hit_lo[i]);
        ch_r[i].rd_hi  <= ~done[i] & ch_r[i].full
                          & (ch_r[i].rd_hi | hit_hi[i]);
        ch_r[i].master <= (ev[i] & ch_r[i].full & ~done[i])
                          | (ch_r[i].master & ~done[i]);
        if (done[i])
          ch_r[i].ovf <= ch_r[i].master;
        ch_r[i].flag   <= ev[i]
                          | (flg_wr[i] ? flg_wd[i] : ch_r[i].flag);
      end
  end

  assign capture_timer_req = |({wrap_r, ch_r[3].flag, ch_r[2].flag,
                                ch_r[1].flag, ch_r[0].flag} & msk_r);

  // ----------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------
  always_comb
  begin
    rd_val = 8'h00;
    unique case (avs_address)
      A_FLG1:
      begin
        rd_val[`T3C_B_WRAP]  = wrap_r;
        rd_val[`T3C_B_CAP1F] = ch_r[0].flag;
        rd_val[`T3C_B_CAP2F] = ch_r[1].flag;
      end
      A_FLG2:
      begin
        rd_val[`T3C_B_CAP3F] = ch_r[2].flag;
        rd_val[`T3C_B_CAP4F] = ch_r[3].flag;
      end
      A_MSK1:
      begin
        rd_val[`T3C_B_WRAP]  = msk_r[4];
        rd_val[`T3C_B_CAP1F] = msk_r[0];
        rd_val[`T3C_B_CAP2F] = msk_r[1];
      end
      A_MSK2:
      begin
        rd_val[`T3C_B_CAP3F] = msk_r[2];
        rd_val[`T3C_B_CAP4F] = msk_r[3];
      end
      A_CNTL: rd_val = cnt_r[7:0];
      A_CNTH: rd_val = cnt_r[15:8];
      A_TC1:
      begin
        rd_val[`T3C_B_ED2 +: 2] = ed_r[1];
        rd_val[`T3C_B_ED1 +: 2] = ed_r[0];
        rd_val[`T3C_B_SRC]      = src_r;
      end
      A_TC2:
      begin
        rd_val[`T3C_B_OVF2] = ch_r[1].ovf;
        rd_val[`T3C_B_OVF1] = ch_r[0].ovf;
        rd_val[`T3C_B_FCS]  = fcs_r;
        rd_val[`T3C_B_RUN]  = run_r;
      end
      A_TC3:
      begin
        rd_val[`T3C_B_OVF4]     = ch_r[3].ovf;
        rd_val[`T3C_B_OVF3]     = ch_r[2].ovf;
        rd_val[`T3C_B_ED4 +: 2] = ed_r[3];
        rd_val[`T3C_B_ED3 +: 2] = ed_r[2];
      end
      default:
        for (int i = 0; i < 4; i++)
        begin
          if (avs_address == cap_adr(i, 1'b0))
            rd_val = cap_r[i][7:0];
          if (avs_address == cap_adr(i, 1'b1))
            rd_val = cap_r[i][15:8];
        end
    endcase
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic cnt_wr;
  assign cnt_wr = wr_acc && (avs_address == A_CNTL || avs_address == A_CNTH);

  chk_wrap_to_zero: assert property (
    tick && fcs_r && !cnt_wr && cnt_r == 16'hFFFF
    |=> cnt_r == 16'h0000 && wrap_r)
    else $error("counter did not wrap with flag");

  chk_stopped_holds: assert property (
    !run_r && !cnt_wr && !(wr_acc && avs_address == A_FLG1)
    |=> $stable(cnt_r) && !$rose(wrap_r))
    else $error("stopped counter moved");

  chk_instr_rate: assert property (
    run_r && !src_r && fcs_r && instr_en && !cnt_wr
    |=> cnt_r == 16'($past(cnt_r) + 16'h0001)
        ##1 $stable(cnt_r)[*3])
    else $error("internal rate not one per instruction");

  chk_ext_count: assert property (
    run_r && src_r && !cnt_wr && ext_s_r[2] && !ext_s_r[1] && phase_en
    |=> cnt_r != $past(cnt_r))
    else $error("external fall not counted");

  chk_first_capture_pin_idle: assert property (
    !fcs_r |=> !$rose(ch_r[0].full))
    else $error("channel one active in period mode");

  chk_bus_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held more than one cycle");

  for (genvar g = 0; g < 4; g++)
  begin : g_chk
    chk_capture_copy: assert property (
      ev[g] && !ch_r[g].full |=> cap_r[g] == $past(cnt_r)
                                 && ch_r[g].flag && ch_r[g].full)
      else $error("capture did not latch counter");

    chk_keep_unread: assert property (
      ev[g] && ch_r[g].full && !done[g]
      |=> $stable(cap_r[g]) && ch_r[g].master)
      else $error("unread capture overwritten");

    chk_ovf_moves: assert property (
      done[g] && !ev[g] |=> ch_r[g].ovf == $past(ch_r[g].master)
                            && !ch_r[g].master && !ch_r[g].full)
      else $error("overflow not transferred");

    chk_presc_steps: assert property (
      !pin_rise[g] |=> $stable(presc_r[g]))
      else $error("prescaler moved without rising edge");
  end
endmodule

// file: verif/t3c_pin_model.sv
// bench-side source of the capture pins and the external count clock
`timescale 1ns/1ns
module t3c_pin_model (
  // clock
  input  wire logic       core_clk,
  // pins toward the block
  output logic      [3:0] capture_event_pin,
  output logic            external_count_clock
);
  // --------------------
  // level timing
  // --------------------
  // long enough for the half-cycle sampler plus the synchroniser
  localparam int HOLD = 10;

  initial
  begin
    capture_event_pin    = 4'h0;
    external_count_clock = 1'b1;
  end

  task automatic hold_level();
    repeat (HOLD) @(posedge core_clk);
  endtask

  // rise then fall on one capture pin
  task automatic pin_pulse(input int ch);
    @(posedge core_clk);
    capture_event_pin[ch] <= 1'b1;
    hold_level();
    capture_event_pin[ch] <= 1'b0;
    hold_level();
  endtask

  // one falling edge, then back to the idle high level
  task automatic count_edge();
    @(posedge core_clk);
    external_count_clock <= 1'b0;
    hold_level();
    external_count_clock <= 1'b1;
    hold_level();
  endtask
endmodule

// file: verif/t3c_top_test.sv
// self-checking bench for the timer/capture block
`timescale 1ns/1ns
`include "t3c_defines.svh"
module t3c_top_test;
  // --------------------
  // signals
  // --------------------
  logic        core_clk        = 1'b0;
  logic        rst_n           = 1'b0;
  logic [7:0]  avs_address     = 8'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [3:0]  avs_byteenable  = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  capture_event_pin;
  logic        external_count_clock;
  logic        capture_timer_req;
  int          fails   = 0;
  int          checked = 0;
  int          cycles  = 0;
  localparam int LIMIT = 20000;
  localparam logic [7:0] FL1 = {`T3C_BANK_FLAGS1, `T3C_OFF_FLAGS1};
  localparam logic [7:0] MK1 = {`T3C_BANK_MASKS1, `T3C_OFF_MASKS1};
  localparam logic [7:0] FL2 = {`T3C_BANK_FLAGS2, `T3C_OFF_FLAGS2};
  localparam logic [7:0] MK2 = {`T3C_BANK_MASKS2, `T3C_OFF_MASKS2};
  localparam logic [7:0] CLO = {`T3C_BANK_CNT, `T3C_OFF_CNT_LO};
  localparam logic [7:0] CHI = {`T3C_BANK_CNT, `T3C_OFF_CNT_HI};
  localparam logic [7:0] TC1 = {`T3C_BANK_TCTL12, `T3C_OFF_TCTL1};
  localparam logic [7:0] TC2 = {`T3C_BANK_TCTL12, `T3C_OFF_TCTL2};
  localparam logic [7:0] TC3 = {`T3C_BANK_TCTL3, `T3C_OFF_TCTL3};
  localparam logic [7:0] CAP_LO [4] = '{
    {`T3C_BANK_FIRST_CAPTURE_PIN, `T3C_OFF_FIRST_CAPTURE_PIN_LO}, {`T3C_BANK_CAP2, `T3C_OFF_CAP2_LO},
    {`T3C_BANK_CAP34, `T3C_OFF_CAP3_LO}, {`T3C_BANK_CAP34, `T3C_OFF_CAP4_LO}};
  localparam logic [7:0] CAP_HI [4] = '{
    {`T3C_BANK_FIRST_CAPTURE_PIN, `T3C_OFF_FIRST_CAPTURE_PIN_HI}, {`T3C_BANK_CAP2, `T3C_OFF_CAP2_HI},
    {`T3C_BANK_CAP34, `T3C_OFF_CAP3_HI}, {`T3C_BANK_CAP34, `T3C_OFF_CAP4_HI}};
  localparam logic [7:0] FLG_A [4] = '{FL1, FL1, FL2, FL2};
  localparam int FLG_B [4] = '{`T3C_B_CAP1F, `T3C_B_CAP2F,
                               `T3C_B_CAP3F, `T3C_B_CAP4F};
  localparam logic [7:0] OVF_A [4] = '{TC2, TC2, TC3, TC3};
  localparam int OVF_B [4] = '{`T3C_B_OVF1, `T3C_B_OVF2,
                               `T3C_B_OVF3, `T3C_B_OVF4};
  localparam int NEV [4] = '{1, 1, 4, 16};
  localparam logic [15:0] KVAL [4] = '{16'h1234, 16'hA55A, 16'h00FF,
                                       16'hFF00};

  always #2 core_clk = ~core_clk;

  // --------------------
  // instances
  // --------------------
  t3c_top i_t3c_top (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_writedata        (avs_writedata),
    .avs_byteenable       (avs_byteenable),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .capture_event_pin    (capture_event_pin),
    .external_count_clock (external_count_clock),
    .capture_timer_req    (capture_timer_req)
  );

  t3c_pin_model i_t3c_pin_model (
    .core_clk             (core_clk),
    .capture_event_pin    (capture_event_pin),
    .external_count_clock (external_count_clock)
  );

  // --------------------
  // bus and check tasks
  // --------------------
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [7:0] wd, output logic [7:0] rdv);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, wd};
    avs_write     <= w;
    avs_read      <= ~w;
    // values read here are those standing just before the edge
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] dummy;
    bus(a, 1'b1, wd, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] rdv);
    bus(a, 1'b0, 8'h00, rdv);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check({8'h00, v}, {8'h00, exp});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      conclude();
    end
  end

  // --------------------
  // tests
  // --------------------
  initial
  begin
    logic [7:0]  d;
    logic [15:0] k;
    logic [7:0]  rst_tab [8];
    logic [7:0]  rw_a [4];
    logic [7:0]  rw_e [4];
    rst_tab = '{FL1, MK1, FL2, MK2, TC1, TC2, TC3, 8'h00};
    rw_a    = '{MK1, MK2, TC1, TC3};
    rw_e    = '{8'h4C, 8'h0C, 8'hF4, 8'h1E};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdchk(rst_tab[i], 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(rw_a[i], 8'hFF);
      rdchk(rw_a[i], rw_e[i]);
      wr(rw_a[i], 8'h00);
    end
    // a write without byte lane zero must be ignored
    avs_byteenable <= 4'h0;
    wr(MK1, 8'hFF);
    avs_byteenable <= 4'h1;
    rdchk(MK1, 8'h00);
    $display("test reset and access done");
    wr(CAP_LO[0], 8'h5A);
    rdchk(CAP_LO[0], 8'h5A);
    wr(TC2, 8'h08);
    wr(CAP_LO[0], 8'hA5);
    rd(CAP_LO[0], d);
    check({15'h0000, d == 8'hA5}, 16'h0000);
    // stopped timer around the byte writes, low then high
    wr(CLO, 8'hFC);
    wr(CHI, 8'hFF);
    wr(TC2, 8'h0C);
    repeat (40) @(posedge core_clk);
    wr(TC2, 8'h08);
    rd(FL1, d);
    check({15'h0000, d[`T3C_B_WRAP]}, 16'h0001);
    rdchk(CHI, 8'h00);
    rd(CLO, d);
    check({15'h0000, d >= 8'h04 && d <= 8'h08}, 16'h0001);
    wr(FL1, 8'h00);
    rdchk(FL1, 8'h00);
    wr(CLO, 8'hFF);
    wr(CHI, 8'hFF);
    repeat (40) @(posedge core_clk);
    rdchk(FL1, 8'h00);
    rdchk(CLO, 8'hFF);
    $display("test wrap and run done");
    wr(TC1, 8'h44);
    wr(TC3, 8'h1C);
    wr(CLO, 8'h00);
    wr(CHI, 8'h00);
    wr(TC2, 8'h0C);
    repeat (40) @(posedge core_clk);
    rdchk(CLO, 8'h00);
    repeat (5) i_t3c_pin_model.count_edge();
    rdchk(CLO, 8'h05);
    rdchk(CHI, 8'h00);
    rdchk(CLO, 8'h05);
    $display("test external count done");
    for (int ch = 0; ch < 4; ch++)
    begin
      k = KVAL[ch];
      wr(CLO, k[7:0]);
      wr(CHI, k[15:8]);
      for (int p = 0; p < NEV[ch]; p++)
      begin
        rd(FLG_A[ch], d);
        check({15'h0000, d[FLG_B[ch]]}, 16'h0000);
        i_t3c_pin_model.pin_pulse(ch);
      end
      rd(FLG_A[ch], d);
      check({15'h0000, d[FLG_B[ch]]}, 16'h0001);
      rdchk(CAP_LO[ch], k[7:0]);
      rdchk(CAP_HI[ch], k[15:8]);
      rd(OVF_A[ch], d);
      check({15'h0000, d[OVF_B[ch]]}, 16'h0000);
      wr(FLG_A[ch], 8'h00);
    end
    $display("test capture channels done");
    wr(CLO, 8'hEF);
    wr(CHI, 8'hBE);
    i_t3c_pin_model.pin_pulse(0);
    wr(CLO, 8'hFE);
    wr(CHI, 8'hCA);
    i_t3c_pin_model.pin_pulse(0);
    rdchk(TC2, 8'h0C);
    rdchk(CAP_HI[0], 8'hBE);
    rdchk(CAP_LO[0], 8'hEF);
    rd(TC2, d);
    check({15'h0000, d[`T3C_B_OVF1]}, 16'h0001);
    wr(MK1, 8'h04);
    @(negedge core_clk);
    check({15'h0000, capture_timer_req}, 16'h0001);
    wr(MK1, 8'h00);
    @(negedge core_clk);
    check({15'h0000, capture_timer_req}, 16'h0000);
    i_t3c_pin_model.pin_pulse(0);
    rdchk(CAP_LO[0], 8'hFE);
    rdchk(CAP_HI[0], 8'hCA);
    rd(TC2, d);
    check({15'h0000, d[`T3C_B_OVF1]}, 16'h0000);
    wr(CLO, 8'h02);
    wr(CHI, 8'h01);
    i_t3c_pin_model.pin_pulse(0);
    rdchk(CAP_LO[0], 8'h02);
    wr(CLO, 8'h03);
    i_t3c_pin_model.pin_pulse(0);
    rdchk(CAP_HI[0], 8'h01);
    rd(TC2, d);
    check({15'h0000, d[`T3C_B_OVF1]}, 16'h0001);
    $display("test overflow done");
    conclude();
  end
endmodule
